/* verilog/cpcr_regs.sv */
// page-zero control and status register bank
// assumes a control-port engine on ref_clk_in giving one-cycle write and read strobes
module cpcr_regs #(
  parameter int Q0 = cpcr_pkg::QCHG_US0 * cpcr_pkg::CLK_MHZ,
  parameter int Q1 = cpcr_pkg::QCHG_US1 * cpcr_pkg::CLK_MHZ,
  parameter int Q2 = cpcr_pkg::QCHG_US2 * cpcr_pkg::CLK_MHZ,
  parameter int Q3 = cpcr_pkg::QCHG_US3 * cpcr_pkg::CLK_MHZ
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       wr_en_in,
  input  wire logic       rd_en_in,
  input  wire logic [6:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       analog_high_in,
  input  wire logic       io_high_in,
  input  wire logic       undervoltage_in,
  output logic [7:0]      rdata_out,
  output logic [7:0]      page_out,
  output logic            awake_not_sleep_out,
  output logic            digital_regulator_en_out,
  output logic            reference_en_out,
  output logic            reference_charging_out,
  output logic            analog_supply_mode_out,
  output logic            io_supply_mode_out,
  output logic [7:0]      channel_enable_bits_out
);
  // each charge count must be nonzero and fit the 23-bit timer
  if (Q0 < 1 || Q1 < 1 || Q2 < 1 || Q3 < 1 ||
      Q0 >= (1 << 23) || Q1 >= (1 << 23) || Q2 >= (1 << 23) || Q3 >= (1 << 23)) begin : g_bad_charge
    $error("charge counts out of range");
  end

  logic [7:0] page_select;
  logic       soft_reset_request;
  logic [7:0] reference_sleep_config;
  logic       undervoltage_wake_select;
  logic       undervoltage_shutdown_flag;
  logic [7:0] signal_proc_config0, signal_proc_config1, channel_enable;
  logic [7:0] dynamic_power_config, power_config, control_checksum;
  logic       analog_supply_override_flag, io_supply_override_flag;
  logic       a_hi, io_hi, uv;
  logic       on_page0, wr_hit, do_reset;
  logic       awake_req, charge_busy, charge_done;
  logic [22:0] charge_cycles;
  logic [7:0] next_rdata;
  logic       uv_prev;
  cpcr_pkg::cpcr_state_t state;

  cpcr_sync u_sync_a  (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .async_in(analog_high_in),  .sync_out(a_hi));
  cpcr_sync u_sync_io (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .async_in(io_high_in),      .sync_out(io_hi));
  cpcr_sync u_sync_uv (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .async_in(undervoltage_in), .sync_out(uv));

  assign on_page0 = (page_select == cpcr_pkg::RST_ZERO);
  assign wr_hit   = wr_en_in && (on_page0 || addr_in == cpcr_pkg::OFS_PAGE);
  assign do_reset = rst_in || soft_reset_request;

  // page selector, reachable on every page
  always_ff @(posedge ref_clk_in) begin
    if (do_reset)
      page_select <= cpcr_pkg::RST_ZERO;
    else if (wr_en_in && addr_in == cpcr_pkg::OFS_PAGE)
      page_select <= wdata_in;
  end

  // soft reset request, clears itself on the same edge where it acts
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || soft_reset_request)
      soft_reset_request <= 1'b0;
    else if (wr_hit && addr_in == cpcr_pkg::OFS_RESET)
      soft_reset_request <= wdata_in[cpcr_pkg::BIT_SWRST];
  end

  // configuration registers
  always_ff @(posedge ref_clk_in) begin
    if (do_reset) begin
      reference_sleep_config   <= cpcr_pkg::RST_ZERO;
      undervoltage_wake_select <= 1'b0;
      signal_proc_config0      <= cpcr_pkg::RST_SPCFG;
      signal_proc_config1      <= cpcr_pkg::RST_SPCFG;
      channel_enable           <= cpcr_pkg::RST_CHEN;
      dynamic_power_config     <= cpcr_pkg::RST_ZERO;
      power_config             <= cpcr_pkg::RST_ZERO;
      control_checksum         <= cpcr_pkg::RST_ZERO;
    end else begin
      if (wr_hit) begin
        case (addr_in)
          cpcr_pkg::OFS_REFCFG: reference_sleep_config <= wdata_in & cpcr_pkg::MASK_REFCFG;
          cpcr_pkg::OFS_SUPPLY: undervoltage_wake_select <= wdata_in[cpcr_pkg::BIT_UVWAKE];
          cpcr_pkg::OFS_SPCFG0: signal_proc_config0 <= wdata_in;
          cpcr_pkg::OFS_SPCFG1: signal_proc_config1 <= wdata_in;
          cpcr_pkg::OFS_CHEN:   channel_enable <= wdata_in;
          cpcr_pkg::OFS_DYNPWR: dynamic_power_config <= wdata_in;
          cpcr_pkg::OFS_PWRCFG: power_config <= wdata_in;
          cpcr_pkg::OFS_CKSUM:  control_checksum <= wdata_in;
          default: ;
        endcase
      end
      // shutdown leaves the device asleep unless wake is selected
      if (uv && !uv_prev)
        reference_sleep_config[cpcr_pkg::BIT_AWAKE] <= undervoltage_wake_select;
    end
  end

  // supply override and shutdown status
  always_ff @(posedge ref_clk_in) begin
    if (do_reset) begin
      analog_supply_override_flag <= 1'b0;
      io_supply_override_flag     <= 1'b0;
      undervoltage_shutdown_flag  <= 1'b0;
    end else begin
      analog_supply_override_flag <= a_hi;
      io_supply_override_flag     <= io_hi;
      if (uv && !uv_prev)
        undervoltage_shutdown_flag <= 1'b1;
    end
  end

  // edge memory survives soft reset, so a shutdown input still high is not seen twice
  always_ff @(posedge ref_clk_in) begin
    if (rst_in)
      uv_prev <= 1'b0;
    else
      uv_prev <= uv;
  end

  // effective modes
  always_ff @(posedge ref_clk_in) begin
    if (do_reset) begin
      analog_supply_mode_out  <= 1'b0;
      io_supply_mode_out      <= 1'b0;
      channel_enable_bits_out <= cpcr_pkg::RST_CHEN;
      page_out                <= cpcr_pkg::RST_ZERO;
    end else begin
      analog_supply_mode_out  <= reference_sleep_config[cpcr_pkg::BIT_AMODE] && !analog_supply_override_flag;
      io_supply_mode_out      <= reference_sleep_config[cpcr_pkg::BIT_IOMODE] && !io_supply_override_flag;
      channel_enable_bits_out <= channel_enable;
      page_out                <= page_select;
    end
  end

  // sleep sequencer with reference quick-charge
  assign awake_req = reference_sleep_config[cpcr_pkg::BIT_AWAKE];
  always_comb begin
    case (reference_sleep_config[cpcr_pkg::BIT_QCHG_LO +: 2])
      2'h0:    charge_cycles = 23'(Q0);
      2'h1:    charge_cycles = 23'(Q1);
      2'h2:    charge_cycles = 23'(Q2);
      default: charge_cycles = 23'(Q3);
    endcase
  end

  cpcr_charge_timer #(.CW(23)) u_timer (
    .ref_clk_in (ref_clk_in),
    .rst_in     (do_reset),
    .start_in   (state == cpcr_pkg::CPCR_ASLEEP && awake_req && reference_sleep_config[cpcr_pkg::BIT_VREF_EN]),
    .cycles_in  (charge_cycles),
    .busy_out   (charge_busy),
    .done_out   (charge_done)
  );

  always_ff @(posedge ref_clk_in) begin
    if (do_reset) begin
      state                    <= cpcr_pkg::CPCR_ASLEEP;
      awake_not_sleep_out      <= 1'b0;
      digital_regulator_en_out <= 1'b0;
      reference_en_out         <= 1'b0;
      reference_charging_out   <= 1'b0;
    end else begin
      reference_charging_out <= charge_busy;
      case (state)
        cpcr_pkg::CPCR_ASLEEP: begin
          if (awake_req) begin
            digital_regulator_en_out <= 1'b1;
            if (reference_sleep_config[cpcr_pkg::BIT_VREF_EN]) begin
              reference_en_out <= 1'b1;
              state            <= cpcr_pkg::CPCR_CHARGE;
            end else begin
              awake_not_sleep_out <= 1'b1;
              state               <= cpcr_pkg::CPCR_AWAKE;
            end
          end
        end
        cpcr_pkg::CPCR_CHARGE: begin
          if (!awake_req) begin
            state                    <= cpcr_pkg::CPCR_ASLEEP;
            digital_regulator_en_out <= 1'b0;
            reference_en_out         <= 1'b0;
          end else if (charge_done) begin
            awake_not_sleep_out <= 1'b1;
            state               <= cpcr_pkg::CPCR_AWAKE;
          end
        end
        cpcr_pkg::CPCR_AWAKE: begin
          if (!awake_req) begin
            state                    <= cpcr_pkg::CPCR_ASLEEP;
            awake_not_sleep_out      <= 1'b0;
            digital_regulator_en_out <= 1'b0;
            reference_en_out         <= 1'b0;
          end
        end
        default: state <= cpcr_pkg::CPCR_ASLEEP;
      endcase
    end
  end

  // read mux
  always_comb begin
    next_rdata = cpcr_pkg::RST_ZERO;
    if (addr_in == cpcr_pkg::OFS_PAGE)
      next_rdata = page_select;
    else if (on_page0) begin
      case (addr_in)
        cpcr_pkg::OFS_RESET:   next_rdata = {7'h00, soft_reset_request};
        cpcr_pkg::OFS_REFCFG:  next_rdata = {reference_sleep_config[7:3], analog_supply_mode_out,
                                             io_supply_mode_out, reference_sleep_config[0]};
        cpcr_pkg::OFS_SUPPLY:  next_rdata = {analog_supply_override_flag, io_supply_override_flag, 4'h0,
                                             undervoltage_shutdown_flag, undervoltage_wake_select};
        cpcr_pkg::OFS_SPCFG0:  next_rdata = signal_proc_config0;
        cpcr_pkg::OFS_SPCFG1:  next_rdata = signal_proc_config1;
        cpcr_pkg::OFS_CHEN:    next_rdata = channel_enable;
        cpcr_pkg::OFS_DYNPWR:  next_rdata = dynamic_power_config;
        cpcr_pkg::OFS_PWRCFG:  next_rdata = power_config;
        cpcr_pkg::OFS_DEVSTS0: next_rdata = {7'h00, awake_not_sleep_out};
        cpcr_pkg::OFS_DEVSTS1: next_rdata = cpcr_pkg::RST_DEVSTS1;
        cpcr_pkg::OFS_CKSUM:   next_rdata = control_checksum;
        default:               next_rdata = cpcr_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in)
      rdata_out <= cpcr_pkg::RST_ZERO;
    else if (rd_en_in)
      rdata_out <= next_rdata;
  end

  property p_page_write;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_en_in && addr_in == cpcr_pkg::OFS_PAGE && !soft_reset_request) |=> page_select == $past(wdata_in);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write lost");

  property p_reset_clears;
    @(posedge ref_clk_in) disable iff (rst_in)
    soft_reset_request |=> !soft_reset_request && channel_enable == cpcr_pkg::RST_CHEN;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("soft reset not applied");

  property p_reset_defaults;
    @(posedge ref_clk_in) disable iff (rst_in)
    soft_reset_request |=> signal_proc_config0 == cpcr_pkg::RST_SPCFG && page_select == cpcr_pkg::RST_ZERO;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not restored");

  property p_amode_forced;
    @(posedge ref_clk_in) disable iff (rst_in || soft_reset_request)
    analog_supply_override_flag |=> !analog_supply_mode_out;
  endproperty
  a_amode_forced: assert property (p_amode_forced) else $error("analog mode not forced");

  property p_iomode_forced;
    @(posedge ref_clk_in) disable iff (rst_in || soft_reset_request)
    io_supply_override_flag |=> !io_supply_mode_out;
  endproperty
  a_iomode_forced: assert property (p_iomode_forced) else $error("io mode not forced");

  property p_uv_flag;
    @(posedge ref_clk_in) disable iff (rst_in || soft_reset_request)
    (uv && !uv_prev) |=> undervoltage_shutdown_flag;
  endproperty
  a_uv_flag: assert property (p_uv_flag) else $error("shutdown flag not set");

  property p_sleep_held;
    @(posedge ref_clk_in) disable iff (rst_in || soft_reset_request)
    !awake_req [*2] |-> !awake_not_sleep_out;
  endproperty
  a_sleep_held: assert property (p_sleep_held) else $error("awake while sleep selected");

  property p_digital_regulator_only;
    @(posedge ref_clk_in) disable iff (rst_in || soft_reset_request)
    (state == cpcr_pkg::CPCR_ASLEEP && awake_req && !reference_sleep_config[cpcr_pkg::BIT_VREF_EN])
      |=> digital_regulator_en_out && !reference_en_out && awake_not_sleep_out;
  endproperty
  a_digital_regulator_only: assert property (p_digital_regulator_only) else $error("wrong wake power set");

  property p_charge_start;
    @(posedge ref_clk_in) disable iff (rst_in || soft_reset_request)
    (state == cpcr_pkg::CPCR_ASLEEP && awake_req && reference_sleep_config[cpcr_pkg::BIT_VREF_EN])
      |=> ##1 reference_charging_out;
  endproperty
  a_charge_start: assert property (p_charge_start) else $error("charge not started");

  property p_off_page_write;
    @(posedge ref_clk_in) disable iff (rst_in || soft_reset_request)
    (wr_en_in && !on_page0 && addr_in == cpcr_pkg::OFS_CHEN) |=> channel_enable == $past(channel_enable);
  endproperty
  a_off_page_write: assert property (p_off_page_write) else $error("write taken off page zero");

  property p_uv_wake;
    @(posedge ref_clk_in) disable iff (rst_in || soft_reset_request)
    (uv && !uv_prev) |=> reference_sleep_config[cpcr_pkg::BIT_AWAKE] == $past(undervoltage_wake_select);
  endproperty
  a_uv_wake: assert property (p_uv_wake) else $error("shutdown wake choice not applied");

  property p_charge_wake;
    @(posedge ref_clk_in) disable iff (rst_in || soft_reset_request)
    (state == cpcr_pkg::CPCR_CHARGE && awake_req && charge_done) |=> awake_not_sleep_out;
  endproperty
  a_charge_wake: assert property (p_charge_wake) else $error("not awake after charge");
endmodule // cpcr_regs

/* verilog/cpcr_pkg.sv */
// constants for the page-zero control register bank
// assumes one 40 MHz clock and a synchronous active-high reset
package cpcr_pkg;
  localparam logic [6:0] OFS_PAGE     = 7'h00;
  localparam logic [6:0] OFS_RESET    = 7'h01;
  localparam logic [6:0] OFS_REFCFG   = 7'h02;
  localparam logic [6:0] OFS_SUPPLY   = 7'h03;
  localparam logic [6:0] OFS_SPCFG0   = 7'h72;
  localparam logic [6:0] OFS_SPCFG1   = 7'h73;
  localparam logic [6:0] OFS_CHEN     = 7'h76;
  localparam logic [6:0] OFS_DYNPWR   = 7'h77;
  localparam logic [6:0] OFS_PWRCFG   = 7'h78;
  localparam logic [6:0] OFS_DEVSTS0  = 7'h79;
  localparam logic [6:0] OFS_DEVSTS1  = 7'h7A;
  localparam logic [6:0] OFS_CKSUM    = 7'h7E;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_SPCFG    = 8'h18;
  localparam logic [7:0] RST_CHEN     = 8'hCC;
  localparam logic [7:0] RST_DEVSTS1  = 8'h80;
  localparam int         BIT_SWRST    = 0;
  localparam int         BIT_QCHG_LO  = 4;
  localparam int         BIT_VREF_EN  = 3;
  localparam int         BIT_AMODE    = 2;
  localparam int         BIT_IOMODE   = 1;
  localparam int         BIT_AWAKE    = 0;
  localparam int         BIT_AFLAG    = 7;
  localparam int         BIT_IOFLAG   = 6;
  localparam int         BIT_UVFLAG   = 1;
  localparam int         BIT_UVWAKE   = 0;
  localparam logic [7:0] MASK_REFCFG  = 8'h3F;
  localparam logic [7:0] MASK_UVWAKE  = 8'h01;
  // quick-charge times in microseconds
  localparam int         QCHG_US0     = 3500;
  localparam int         QCHG_US1     = 10000;
  localparam int         QCHG_US2     = 50000;
  localparam int         QCHG_US3     = 100000;
  localparam int         CLK_MHZ      = 40;
  typedef enum logic [1:0] {CPCR_ASLEEP, CPCR_CHARGE, CPCR_AWAKE} cpcr_state_t;
endpackage

/* verilog/cpcr_sync.sv */
// two-flop synchroniser for one level
// assumes the input is asynchronous to ref_clk_in
module cpcr_sync (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // cpcr_sync

/* verilog/cpcr_charge_timer.sv */
// quick-charge timer: counts the selected charge time
// assumes start is a one-cycle pulse on ref_clk_in
module cpcr_charge_timer #(
  parameter int CW = 23
) (
  input  wire logic          ref_clk_in,
  input  wire logic          rst_in,
  input  wire logic          start_in,
  input  wire logic [CW-1:0] cycles_in,
  output logic               busy_out,
  output logic               done_out
);
  logic [CW-1:0] count;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      count    <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count    <= cycles_in;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (count <= CW'(1)) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count <= count - CW'(1);
        end
      end
    end
  end
endmodule // cpcr_charge_timer

/* testbench/cpcr_host.sv */
// host model that drives the register port with one-cycle strobes
// assumes the bench holds reset until the first request
module cpcr_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            wr_en_out,
  output logic            rd_en_out,
  output logic [6:0]      addr_out,
  output logic [7:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out  = 7'h7F;
    wdata_out = 8'hFF;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask
  // reserved bits 7-6 go out as zero
  task automatic wr_ref(input logic [7:0] d);
    wr(cpcr_pkg::OFS_REFCFG, d & cpcr_pkg::MASK_REFCFG);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    addr_out  <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out  <= ~a;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask
  // soft reset, then settle before any other access
  task automatic soft_reset();
    wr(cpcr_pkg::OFS_RESET, 8'h01);
    repeat (2) @(posedge clk_in);
  endtask
endmodule  // cpcr_host

/* testbench/testbench.sv */
// self-checking bench for the page-zero register bank
// assumes cpcr_regs with shortened charge counts and the host model
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q[4] = '{10, 20, 30, 40};
  localparam logic [6:0] OFS[12] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h72, 7'h73, 7'h76, 7'h77, 7'h78, 7'h79,
                                     7'h7A, 7'h7E};
  localparam logic [7:0] DEF[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h18, 8'hCC, 8'h00, 8'h00, 8'h00,
                                     8'h80, 8'h00};
  logic       ref_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       wr_en, rd_en, analog_high, io_high, undervoltage;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, page, chen;
  logic       awake, digital_regulator_en, vref_en, charging, amode, iomode;
  int         mismatches = 0;
  int         tests_run = 0;
  int         cnt;
  bit         seen;
  always #12.5 ref_clk_in = ~ref_clk_in;
  cpcr_regs #(.Q0(Q[0]), .Q1(Q[1]), .Q2(Q[2]), .Q3(Q[3])) cpcr_regs_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
    .wdata_in(wdata), .analog_high_in(analog_high), .io_high_in(io_high), .undervoltage_in(undervoltage),
    .rdata_out(rdata), .page_out(page), .awake_not_sleep_out(awake), .digital_regulator_en_out(digital_regulator_en),
    .reference_en_out(vref_en), .reference_charging_out(charging), .analog_supply_mode_out(amode),
    .io_supply_mode_out(iomode), .channel_enable_bits_out(chen));
  cpcr_host cpcr_host_i (.clk_in(ref_clk_in), .rdata_in(rdata), .wr_en_out(wr_en), .rd_en_out(rd_en),
    .addr_out(addr), .wdata_out(wdata));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpcr_host_i.rd(a, d);
    check(d, exp);
  endtask
  task automatic wait_sync();
    repeat (5) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {analog_high, io_high, undervoltage} = 3'b000;
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    check(chen, 8'hCC);
    for (int i = 0; i < 12; i++) rchk(OFS[i], DEF[i]);
    rchk(7'h10, 8'h00);
    for (int i = 4; i < 12; i++) cpcr_host_i.wr(OFS[i], 8'hA5);
    for (int i = 4; i < 12; i++) rchk(OFS[i], (i == 9 || i == 10) ? DEF[i] : 8'hA5);
    check(chen, 8'hA5);
    cpcr_host_i.wr(7'h00, 8'h05);
    cpcr_host_i.wr(7'h76, 8'h11);
    check(page, 8'h05);
    rchk(7'h76, 8'h00);
    cpcr_host_i.wr(7'h00, 8'hFF);
    wait_sync();
    check(page, 8'hFF);
    cpcr_host_i.wr(7'h00, 8'h00);
    rchk(7'h76, 8'hA5);
    cpcr_host_i.wr_ref(8'h36);
    rchk(7'h02, 8'h36);
    check(8'({awake, amode, iomode}), 8'h03);
    cpcr_host_i.wr_ref(8'h37);
    wait_sync();
    check(8'({awake, digital_regulator_en, vref_en}), 8'h06);
    for (int k = 0; k < 4; k++) begin
      cpcr_host_i.wr_ref(8'(k * 16 + 8));
      wait_sync();
      check(8'(awake), 8'h00);
      cpcr_host_i.wr_ref(8'(k * 16 + 9));
      cnt = 0;
      seen = 1'b0;
      while (awake !== 1'b1 && cnt < 200) begin
        @(posedge ref_clk_in);
        #1;
        cnt++;
        if (charging === 1'b1 && vref_en === 1'b1) seen = 1'b1;
      end
      check(8'(cnt >= Q[k] && cnt <= Q[k] + 4 && seen), 8'h01);
    end
    cpcr_host_i.wr_ref(8'h07);
    analog_high <= 1'b1;
    wait_sync();
    rchk(7'h03, 8'h80);
    check(8'({amode, iomode}), 8'h01);
    rchk(7'h02, 8'h03);
    io_high <= 1'b1;
    wait_sync();
    rchk(7'h03, 8'hC0);
    check(8'({amode, iomode}), 8'h00);
    rchk(7'h02, 8'h01);
    {analog_high, io_high} <= 2'b00;
    wait_sync();
    rchk(7'h03, 8'h00);
    check(8'({amode, iomode}), 8'h03);
    cpcr_host_i.wr(7'h03, 8'h01);
    cpcr_host_i.wr_ref(8'h00);
    rchk(7'h03, 8'h01);
    undervoltage <= 1'b1;
    wait_sync();
    rchk(7'h03, 8'h03);
    check(8'(awake), 8'h01);
    undervoltage <= 1'b0;
    cpcr_host_i.wr(7'h03, 8'h00);
    wait_sync();
    check(8'(awake), 8'h01);
    undervoltage <= 1'b1;
    wait_sync();
    check(8'(awake), 8'h00);
    rchk(7'h03, 8'h02);
    cpcr_host_i.wr(7'h01, 8'h00);
    rchk(7'h76, 8'hA5);
    cpcr_host_i.soft_reset();
    rchk(7'h01, 8'h00);
    for (int i = 0; i < 12; i++) rchk(OFS[i], DEF[i]);
    check(chen, 8'hCC);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    mismatches++;
    report_and_stop();
  end
endmodule  // testbench
